// file: rtl/ppx_pkg.sv
package ppx_pkg;

  // ****************************************
  // Register map (word index on the plain port)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_PORT   = 4'h0;
  localparam logic [3:0] OFS_DIR    = 4'h1;
  localparam logic [3:0] OFS_ANALOG = 4'h2;
  localparam logic [3:0] OFS_PULLUP = 4'h3;
  localparam logic [3:0] OFS_CHANGE = 4'h4;
  localparam logic [3:0] OFS_IRQ    = 4'h5;
  localparam logic [3:0] OFS_POWER  = 4'h6;
  localparam logic [3:0] OFS_OPTION = 4'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_GLOBAL_IRQ   = 7;
  localparam int BIT_CHANGE_IRQ   = 3;
  localparam int BIT_CHANGE_FLAG  = 0;
  localparam int BIT_WAKE_ENABLE  = 5;
  localparam int BIT_GLOBAL_PULL  = 7;
  localparam int BIT_PIN_THREE    = 3;

  // ****************************************
  // Reset values and fixed masks
  // ****************************************
  localparam logic [5:0] DIR_RST      = 6'h3F;
  localparam logic [3:0] ANALOG_RST   = 4'hF;
  localparam logic [5:0] PULLUP_RST   = 6'h37;
  localparam logic [5:0] PULLUP_MASK  = 6'h37;
  localparam logic [5:0] XTAL_PINS    = 6'h30;
  localparam logic [11:0] IRQ_VECTOR  = 12'h004;

  typedef struct packed {
    logic [5:0] out_latch;
    logic [5:0] direction_reg;
    logic [2:0] conv_clock_select;
    logic [3:0] analog_pin_select;
    logic [5:0] pullup_enable_bits;
    logic [5:0] change_irq_enable_bits;
    logic       global_irq_enable;
    logic       change_irq_on;
    logic       port_change_flag;
    logic       lowpower_wake_enable;
    logic       global_pullup_control;
    logic [5:0] last_read;
    logic [7:0] rdata;
    logic [5:0] pullup_on;
    logic [5:0] pin_oe;
    logic [5:0] pin_out;
    logic [5:0] analog_pins;
    logic       irq;
    logic       wake;
    logic       wake_vector;
    logic       lowpower_wake_sink;
    logic [2:0] conv_div_log2;
    logic       conv_use_osc;
  } ppx_state_t;

  localparam ppx_state_t PPX_RST = '{
    direction_reg:         DIR_RST,
    analog_pin_select:     ANALOG_RST,
    pullup_enable_bits:    PULLUP_RST,
    global_pullup_control: 1'h1,
    pin_oe:                6'h00,
    conv_div_log2:         3'h1,
    default:               '0
  };

endpackage

// file: rtl/ppx_sync.sv
module ppx_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // ****************************************
  // Two-stage synchroniser; meta feeds only q
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// file: rtl/ppx_port_extras.sv
// Notes on behaviour
// - Analog-selected pin reads back as zero.
// - Analog select leaves output drive untouched.
// - Per-pin pull-up except pin three.
// - Output-configured pin forces its pull-up off.
// - Global pull-up control gates all but pin three; off after power-on.
// - Pin three pull-up follows master clear mode.
// - Six change enables, cleared at power-on.
// - Enabled pin mismatches ORed into change flag.
// - Mismatch re-sets flag; port access ends mismatch.
// - Last-read latch survives master-clear and brown-out.
// - Change coinciding with port access still sets the flag.
// - Change event wakes device from sleep.
// - Conversion clock select decodes divider or oscillator.
// - Analog select disables input, pull-up, change detect.
// - Crystal modes: pull-up bits five, four read one.
// - Crystal modes: change bits five, four read zero.
// - Interrupt needs global enable plus per-pin enable.
// - Wake enable bit turns on pin zero sink.
// - Wake vectors to 0004h if global enable set.
// - Port read gives pins; write sets output latch.
module ppx_port_extras (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      soft_rst,
  input  wire logic [ppx_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [7:0]                rdata,
  input  wire logic [5:0]                pin_in,
  output logic      [5:0]                pin_out,
  output logic      [5:0]                pin_oe,
  output logic      [5:0]                pullup_on,
  output logic      [5:0]                analog_pins,
  input  wire logic                      cfg_master_clear_pin,
  input  wire logic                      cfg_xtal_mode,
  input  wire logic                      sleeping,
  output logic                           irq,
  output logic                           wake,
  output logic                           wake_vector,
  output logic      [11:0]               wake_vector_addr,
  output logic                           lowpower_wake_sink,
  output logic      [2:0]                conv_div_log2,
  output logic                           conv_use_osc
);

  ppx_pkg::ppx_state_t s;
  ppx_pkg::ppx_state_t next_s;

  logic [5:0] pin_sync;
  logic [5:0] amask;
  logic [5:0] pin_dig;
  logic [5:0] change_eff;
  logic [5:0] mismatch;
  logic       change_set;
  logic       port_access;
  logic [5:0] pullup_read;
  logic [5:0] change_read;

  // ****************************************
  // Pin input synchronisation
  // ****************************************
  ppx_sync #(.W(6)) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   (pin_in),
    .q   (pin_sync)
  );

  // Log2 of the divider; code x11 selects the dedicated conversion oscillator
  function automatic logic [2:0] conv_log2(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h1;
    unique case (code)
      3'h0: r = 3'h1;
      3'h1: r = 3'h3;
      3'h2: r = 3'h5;
      3'h4: r = 3'h2;
      3'h5: r = 3'h4;
      3'h6: r = 3'h6;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // ****************************************
  // Pin-level derived terms
  // ****************************************
  // Analog channels sit on pins 0, 1, 2 and 4
  assign amask = {1'h0, s.analog_pin_select[3], 1'h0, s.analog_pin_select[2:0]};

  always_comb begin
    pin_dig = pin_sync & ~amask;
    if (cfg_master_clear_pin) begin
      pin_dig[ppx_pkg::BIT_PIN_THREE] = 1'h0;
    end
  end

  // Crystal pins are oscillator connections, so change detect is masked there too
  assign change_eff = s.change_irq_enable_bits & ~amask
                      & ~(cfg_xtal_mode ? ppx_pkg::XTAL_PINS : 6'h00);
  assign mismatch   = (pin_dig ^ s.last_read) & change_eff;
  assign change_set = |mismatch;
  assign port_access = (rd_en || wr_en) && (addr == ppx_pkg::OFS_PORT);

  assign pullup_read = {cfg_xtal_mode ? 2'h3 : s.pullup_enable_bits[5:4], 1'h0,
                        s.pullup_enable_bits[2:0]};
  assign change_read = {cfg_xtal_mode ? 2'h0 : s.change_irq_enable_bits[5:4],
                        s.change_irq_enable_bits[3:0]};

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;

    if (wr_en) begin
      unique case (addr)
        ppx_pkg::OFS_PORT: begin
          next_s.out_latch = wdata[5:0];
        end
        ppx_pkg::OFS_DIR: begin
          next_s.direction_reg = wdata[5:0] | 6'h08;
        end
        ppx_pkg::OFS_ANALOG: begin
          next_s.conv_clock_select = wdata[6:4];
          next_s.analog_pin_select = wdata[3:0];
        end
        ppx_pkg::OFS_PULLUP: begin
          next_s.pullup_enable_bits = wdata[5:0] & ppx_pkg::PULLUP_MASK;
        end
        ppx_pkg::OFS_CHANGE: begin
          next_s.change_irq_enable_bits = wdata[5:0];
        end
        ppx_pkg::OFS_IRQ: begin
          next_s.global_irq_enable = wdata[ppx_pkg::BIT_GLOBAL_IRQ];
          next_s.change_irq_on     = wdata[ppx_pkg::BIT_CHANGE_IRQ];
        end
        ppx_pkg::OFS_POWER: begin
          next_s.lowpower_wake_enable = wdata[ppx_pkg::BIT_WAKE_ENABLE];
        end
        ppx_pkg::OFS_OPTION: begin
          next_s.global_pullup_control = wdata[ppx_pkg::BIT_GLOBAL_PULL];
        end
        default: begin
        end
      endcase
    end

    if (rd_en) begin
      unique case (addr)
        ppx_pkg::OFS_PORT:   next_s.rdata = {2'h0, pin_dig};
        ppx_pkg::OFS_DIR:    next_s.rdata = {2'h0, s.direction_reg};
        ppx_pkg::OFS_ANALOG: next_s.rdata = {1'h0, s.conv_clock_select, s.analog_pin_select};
        ppx_pkg::OFS_PULLUP: next_s.rdata = {2'h0, pullup_read};
        ppx_pkg::OFS_CHANGE: next_s.rdata = {2'h0, change_read};
        ppx_pkg::OFS_IRQ: begin
          next_s.rdata[ppx_pkg::BIT_GLOBAL_IRQ]  = s.global_irq_enable;
          next_s.rdata[ppx_pkg::BIT_CHANGE_IRQ]  = s.change_irq_on;
          next_s.rdata[ppx_pkg::BIT_CHANGE_FLAG] = s.port_change_flag;
        end
        ppx_pkg::OFS_POWER: begin
          next_s.rdata[ppx_pkg::BIT_WAKE_ENABLE] = s.lowpower_wake_enable;
        end
        ppx_pkg::OFS_OPTION: begin
          next_s.rdata[ppx_pkg::BIT_GLOBAL_PULL] = s.global_pullup_control;
        end
        default: begin
        end
      endcase
    end

    // A change landing in the access cycle still sets the flag before the refresh
    if (port_access) begin
      next_s.last_read = pin_dig;
    end

    // Set beats clear; only a zero write or a warm reset with no mismatch clears
    if (wr_en && (addr == ppx_pkg::OFS_IRQ)) begin
      next_s.port_change_flag = wdata[ppx_pkg::BIT_CHANGE_FLAG] | change_set;
    end else begin
      next_s.port_change_flag = s.port_change_flag | change_set;
    end

    // Pull-up: bit set means globally disabled
    next_s.pullup_on = s.pullup_enable_bits & ppx_pkg::PULLUP_MASK & s.direction_reg
                       & ~amask & {6{~s.global_pullup_control}};
    next_s.pullup_on[ppx_pkg::BIT_PIN_THREE] = cfg_master_clear_pin;

    // Output drive ignores analog select; pin three is input only
    next_s.pin_oe  = ~s.direction_reg & 6'h37;
    next_s.pin_out = s.out_latch;
    next_s.analog_pins = amask;

    next_s.irq  = s.port_change_flag && s.change_irq_on && s.global_irq_enable;
    next_s.wake = s.port_change_flag && s.change_irq_on && sleeping;
    next_s.wake_vector = s.port_change_flag && s.change_irq_on && sleeping
                         && s.global_irq_enable;
    next_s.lowpower_wake_sink = s.lowpower_wake_enable;
    next_s.conv_div_log2 = conv_log2(s.conv_clock_select);
    next_s.conv_use_osc  = (s.conv_clock_select[1:0] == 2'h3);

    // Warm reset: everything returns to power-on values except the last-read latch and a change flag set by a mismatch
    if (soft_rst) begin
      next_s = ppx_pkg::PPX_RST;
      // A port access in the reset cycle still refreshes the latch
      next_s.last_read = port_access ? pin_dig : s.last_read;
      next_s.port_change_flag = change_set;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= ppx_pkg::PPX_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata              = s.rdata;
  assign pin_out            = s.pin_out;
  assign pin_oe             = s.pin_oe;
  assign pullup_on          = s.pullup_on;
  assign analog_pins        = s.analog_pins;
  assign irq                = s.irq;
  assign wake               = s.wake;
  assign wake_vector        = s.wake_vector;
  assign wake_vector_addr   = ppx_pkg::IRQ_VECTOR;
  assign lowpower_wake_sink = s.lowpower_wake_sink;
  assign conv_div_log2      = s.conv_div_log2;
  assign conv_use_osc       = s.conv_use_osc;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_port_read;
    rd_en && (addr == ppx_pkg::OFS_PORT) && !soft_rst;
  endsequence

  sequence s_wake_cause;
    s.port_change_flag && s.change_irq_on && sleeping && !soft_rst;
  endsequence

  sequence s_wake_answer;
    s.wake && (s.wake_vector == $past(s.global_irq_enable));
  endsequence

  property p_analog_read_zero;
    s_port_read |=> ((rdata[5:0] & $past(amask)) == 6'h00);
  endproperty
  a_analog_read_zero: assert property (p_analog_read_zero)
    else $error("analog pin read back nonzero");

  property p_output_drive;
    !soft_rst |=> (pin_oe == ($past(~s.direction_reg) & 6'h37))
                  && (pin_out == $past(s.out_latch));
  endproperty
  a_output_drive: assert property (p_output_drive)
    else $error("output drive does not follow direction and latch");

  property p_pullup_output_off;
    !soft_rst |=> ((pullup_on & ~$past(s.direction_reg) & 6'h37) == 6'h00);
  endproperty
  a_pullup_output_off: assert property (p_pullup_output_off)
    else $error("pull-up on for an output pin");

  property p_global_pullup;
    s.global_pullup_control |=> ((pullup_on & ppx_pkg::PULLUP_MASK) == 6'h00);
  endproperty
  a_global_pullup: assert property (p_global_pullup)
    else $error("pull-up on while globally disabled");

  property p_pin_three_pullup;
    !soft_rst |=> (pullup_on[3] == $past(cfg_master_clear_pin));
  endproperty
  a_pin_three_pullup: assert property (p_pin_three_pullup)
    else $error("pin three pull-up wrong for master clear mode");

  property p_flag_set;
    change_set |=> s.port_change_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("mismatch did not set change flag");

  property p_flag_clear_cause;
    $fell(s.port_change_flag) |-> $past(soft_rst || (wr_en && addr == ppx_pkg::OFS_IRQ
                                        && !wdata[0] && !change_set));
  endproperty
  a_flag_clear_cause: assert property (p_flag_clear_cause)
    else $error("change flag cleared without a clearing write");

  property p_latch_refresh;
    port_access |=> (s.last_read == $past(pin_dig));
  endproperty
  a_latch_refresh: assert property (p_latch_refresh)
    else $error("port access did not refresh last-read latch");

  property p_latch_kept;
    soft_rst && !port_access |=> (s.last_read == $past(s.last_read));
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("warm reset disturbed last-read latch");

  property p_xtal_reads;
    rd_en && cfg_xtal_mode && (addr == ppx_pkg::OFS_PULLUP) && !soft_rst
      |=> (rdata[5:3] == 3'h6);
  endproperty
  a_xtal_reads: assert property (p_xtal_reads)
    else $error("crystal-mode pull-up read wrong");

  property p_wake;
    s_wake_cause |=> s_wake_answer;
  endproperty
  a_wake: assert property (p_wake)
    else $error("change event did not wake with correct vectoring");

  property p_irq_gie;
    irq |-> $past(s.global_irq_enable);
  endproperty
  a_irq_gie: assert property (p_irq_gie)
    else $error("interrupt raised without global enable");

  property p_conv_osc;
    !soft_rst |=> (conv_use_osc == ($past(s.conv_clock_select[1:0]) == 2'h3));
  endproperty
  a_conv_osc: assert property (p_conv_osc)
    else $error("conversion oscillator select wrong");

  property p_sink;
    !soft_rst |=> (lowpower_wake_sink == $past(s.lowpower_wake_enable));
  endproperty
  a_sink: assert property (p_sink)
    else $error("pin zero sink does not follow enable");

endmodule

// file: sim/ppx_pins_model.sv
module ppx_pins_model #(
  parameter int DISCHARGE = 40
) (
  input  wire logic       clk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pullup_on,
  input  wire logic       sink_on,
  input  wire logic [5:0] ext_drv,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Capacitor on pin zero, floating lines
  // ****************************************
  logic       cap = 1'h0;
  int         cnt = 0;
  logic [5:0] flt = 6'h2A;

  // Sink drains the capacitor only while the pin is not driven
  always @(posedge clk) begin
    flt <= ~flt;
    if (pin_oe[0]) begin
      cap <= pin_out[0];
      cnt <= 0;
    end else if (sink_on) begin
      if (cnt >= DISCHARGE) begin
        cap <= 1'h0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  // Undriven lines other than pin zero without pull-up wander, so a stale level never passes
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pullup_on[i]) pin_in[i] = 1'h1;
      else if (i == 0) pin_in[i] = cap;
      else pin_in[i] = flt[i];
    end
  end
endmodule

// file: sim/test_ppx_port_extras.sv
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_ppx_port_extras;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'h0, rst = 1'h1, soft_rst = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [5:0] pin_in, pin_out, pin_oe, pullup_on, analog_pins;
  logic [5:0] ext_drv = 6'h3F, ext_val = 6'h3F;
  logic cfg_mc = 1'h0, cfg_xtal = 1'h0, sleeping = 1'h0;
  logic irq, wake, wake_vector, sink, conv_use_osc;
  logic [11:0] vec_addr;
  logic [2:0] conv_div_log2;
  int n_checks = 0, n_mismatch = 0;
  logic [2:0] div_tab [8] = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h2, 3'h4, 3'h6, 3'h0};

  always #25 clk = ~clk;

  ppx_port_extras u_dut (
    .clk(clk), .rst(rst), .soft_rst(soft_rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .analog_pins(analog_pins),
    .cfg_master_clear_pin(cfg_mc), .cfg_xtal_mode(cfg_xtal), .sleeping(sleeping),
    .irq(irq), .wake(wake), .wake_vector(wake_vector), .wake_vector_addr(vec_addr),
    .lowpower_wake_sink(sink), .conv_div_log2(conv_div_log2), .conv_use_osc(conv_use_osc));

  ppx_pins_model #(.DISCHARGE(40)) u_pins (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .sink_on(sink), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] ex, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    `CHK($sformatf("reg%0h", a), ex & m, rdata & m)
  endtask

  // Derived outputs land one edge after the register write; two spare edges
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? irq : wake) === 1'h1) break;
    end
    if (i == 100) begin
      n_mismatch++;
      $display("MISMATCH wait%0d exp 1 got 0", sel);
      results();
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    #(50 * 20000);
    n_mismatch++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    settle();
    rdc(4'h1, 8'h3F);
    rdc(4'h2, 8'h0F);
    rdc(4'h3, 8'h37);
    rdc(4'h4, 8'h00);
    rdc(4'h5, 8'h00);
    rdc(4'h6, 8'h00);
    rdc(4'h7, 8'h80, 8'h80);
    rdc(4'h9, 8'h00);
    `CHK("pullup_on", 6'h00, pullup_on)
    done("reset");

    `CHK("analog_pins", 6'h17, analog_pins)
    rdc(4'h0, 8'h28);
    wr(4'h2, 8'h00);
    settle();
    rdc(4'h0, 8'h3F);
    done("analog_read");

    wr(4'h7, 8'h00);
    wr(4'h2, 8'h0F);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h15);
    settle();
    `CHK("pin_oe", 6'h37, pin_oe)
    `CHK("pin_out", 6'h15, pin_out)
    `CHK("pullup_on", 6'h00, pullup_on)
    wr(4'h1, 8'h3F);
    settle();
    `CHK("pullup_on", 6'h20, pullup_on)
    wr(4'h2, 8'h00);
    settle();
    `CHK("pullup_on", 6'h37, pullup_on)
    wr(4'h7, 8'h80);
    @(posedge clk);
    cfg_mc <= 1'h1;
    settle();
    `CHK("pullup_on", 6'h08, pullup_on)
    rdc(4'h0, 8'h37);
    @(posedge clk);
    cfg_mc <= 1'h0;
    settle();
    `CHK("pullup_on", 6'h00, pullup_on)
    done("pullups");

    wr(4'h3, 8'h0F);
    rdc(4'h3, 8'h07);
    @(posedge clk);
    cfg_xtal <= 1'h1;
    settle();
    rdc(4'h3, 8'h37);
    wr(4'h4, 8'h3F);
    rdc(4'h4, 8'h0F);
    @(posedge clk);
    cfg_xtal <= 1'h0;
    wr(4'h4, 8'h00);
    done("crystal");

    rdc(4'h0, 8'h3F);
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h88);
    settle();
    `CHK("irq", 1'h0, irq)
    @(posedge clk);
    ext_val <= 6'h3E;
    wait_for(0);
    rdc(4'h5, 8'h89);
    wr(4'h5, 8'h88);
    settle();
    rdc(4'h5, 8'h89);
    rdc(4'h0, 8'h3E);
    wr(4'h5, 8'h88);
    settle();
    rdc(4'h5, 8'h88);
    `CHK("irq", 1'h0, irq)
    wr(4'h5, 8'h08);
    @(posedge clk);
    ext_val <= 6'h3F;
    settle();
    rdc(4'h5, 8'h09);
    `CHK("irq", 1'h0, irq)
    done("change");

    rdc(4'h0, 8'h3F);
    wr(4'h5, 8'h08);
    @(posedge clk);
    soft_rst <= 1'h1;
    @(posedge clk);
    soft_rst <= 1'h0;
    settle();
    rdc(4'h5, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h08);
    settle();
    rdc(4'h5, 8'h08);
    @(posedge clk);
    ext_val <= 6'h3E;
    settle();
    rdc(4'h5, 8'h09);
    done("soft_reset");

    // Charge, arm, release, enable sink, then sleep
    @(posedge clk);
    ext_drv <= 6'h3E;
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h3E);
    wr(4'h4, 8'h01);
    settle();
    rdc(4'h0, 8'h3F);
    wr(4'h1, 8'h3F);
    wr(4'h6, 8'h20);
    wr(4'h5, 8'h08);
    sleeping <= 1'h1;
    settle();
    `CHK("sink", 1'h1, sink)
    `CHK("wake", 1'h0, wake)
    wait_for(1);
    `CHK("wake_vector", 1'h0, wake_vector)
    wr(4'h5, 8'h89);
    settle();
    `CHK("wake_vector", 1'h1, wake_vector)
    `CHK("vector_addr", 12'h004, vec_addr)
    `CHK("irq", 1'h1, irq)
    sleeping <= 1'h0;
    done("wake");

    for (int c = 0; c < 8; c++) begin
      wr(4'h2, {1'h0, c[2:0], 4'h0});
      settle();
      `CHK("conv_div", div_tab[c], conv_div_log2)
      `CHK("conv_osc", (c[1:0] == 2'h3), conv_use_osc)
    end
    done("conv_clock");
    results();
  end
endmodule
